// File: include/qspc_pkg.sv
// Shared constants, types and helpers of the queued serial control block.
package qspc_pkg;
    // ------------------------------------------------------------------
    // Queue memory layout
    // ------------------------------------------------------------------
    localparam int unsigned RAM_BYTES    = 160;
    localparam int unsigned ENTRIES      = 32;
    localparam int unsigned PTR_W        = 5;
    localparam int unsigned CS_W         = 4;
    localparam logic [7:0]  RX_BASE      = 8'h00;
    localparam logic [7:0]  TX_BASE      = 8'h40;
    localparam logic [7:0]  CMD_BASE     = 8'h80;
    localparam logic [4:0]  PTR_RESET    = 5'h00;
    localparam int unsigned CMD_HOLD_BIT = 7;
    localparam int unsigned CMD_WIDE_BIT = 6;

    // ------------------------------------------------------------------
    // Status flag positions
    // ------------------------------------------------------------------
    localparam int unsigned FLAG_DONE  = 0;
    localparam int unsigned FLAG_MODE_FAULT_FLAG  = 1;
    localparam int unsigned FLAG_HALT_ACKNOWLEDGE_FLAG = 2;
    localparam logic [2:0]  FLAGS_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Serial timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned SCK_HALF_NS  = 250;
    localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  SCK_HALF_END = 8'(SCK_HALF_CYC - 1);
    localparam logic [4:0]  BITS_WIDE    = 5'h10;
    localparam logic [4:0]  BITS_NARROW  = 5'h08;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_XFER = 2'b10,
        ST_HALT = 2'b11
    } qspc_state_t;

    // Byte address of an entry: two bytes per word segment, one per command.
    function automatic logic [7:0] entry_byte(input logic [7:0] base, input logic [4:0] idx,
                                              input logic word, input logic lo);
        entry_byte = word ? base + {2'b00, idx, lo} : base + {3'b000, idx};
    endfunction : entry_byte
endpackage : qspc_pkg

// File: hw/qspc_ram.sv
// Queue memory of receive, transmit and command segments with two ports.
module qspc_ram (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        cpu_wr,
    input  wire logic [7:0]  cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    input  wire logic [4:0]  eng_idx,
    output logic      [15:0] eng_tx,
    output logic      [7:0]  eng_cmd,
    input  wire logic        eng_wr,
    input  wire logic [15:0] eng_rx
);
    typedef struct packed {
        logic [qspc_pkg::RAM_BYTES-1:0][7:0] mem;
        logic [7:0]                          rdata;
    } qspc_ram_t;

    qspc_ram_t q;
    qspc_ram_t d;
    logic      hit;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    assign hit = cpu_addr < 8'(qspc_pkg::RAM_BYTES);

    // The CPU reaches every byte; the engine only ever writes the receive words.
    always_comb begin
        d = q;
        if (cpu_wr && hit) begin
            d.mem[cpu_addr] = cpu_wdata;
        end
        if (eng_wr) begin
            d.mem[qspc_pkg::entry_byte(qspc_pkg::RX_BASE, eng_idx, 1'b1, 1'b0)] = eng_rx[15:8];
            d.mem[qspc_pkg::entry_byte(qspc_pkg::RX_BASE, eng_idx, 1'b1, 1'b1)] = eng_rx[7:0];
        end
        d.rdata = hit ? q.mem[cpu_addr] : 8'h00;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Engine reads transmit and command segments only.
    assign eng_tx    = {q.mem[qspc_pkg::entry_byte(qspc_pkg::TX_BASE, eng_idx, 1'b1, 1'b0)],
                        q.mem[qspc_pkg::entry_byte(qspc_pkg::TX_BASE, eng_idx, 1'b1, 1'b1)]};
    assign eng_cmd   = q.mem[qspc_pkg::entry_byte(qspc_pkg::CMD_BASE, eng_idx, 1'b0, 1'b0)];
    assign cpu_rdata = q.rdata;
endmodule : qspc_ram

// File: hw/qspc_shift.sv
// Serial shifter for one transfer of 8 or 16 bits, master or slave.
module qspc_shift (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic        master,
    input  wire logic        wide,
    input  wire logic [15:0] tx,
    input  wire logic        sck_s,
    input  wire logic        sdi,
    output logic             sck_o,
    output logic             sdo,
    output logic             done,
    output logic      [15:0] rx
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic        sck;
        logic        prev;
        logic [4:0]  cnt;
        logic [7:0]  div;
        logic [15:0] sh;
        logic [15:0] rx;
    } qspc_shift_t;

    qspc_shift_t q;
    qspc_shift_t d;

    // Sample on the rising edge of the serial clock, shift on the falling one.
    always_comb begin
        logic rise;
        logic fall;
        rise   = 1'b0;
        fall   = 1'b0;
        d      = q;
        d.done = 1'b0;
        d.prev = sck_s;
        if (master) begin
            if (q.busy && q.div == qspc_pkg::SCK_HALF_END) begin
                d.div = 8'h00;
                d.sck = !q.sck;
                rise  = !q.sck;
                fall  = q.sck;
            end else if (q.busy) begin
                d.div = q.div + 8'h01;
            end
        end else begin
            rise = sck_s && !q.prev;
            fall = !sck_s && q.prev;
        end
        if (q.busy && rise) begin
            d.rx = {q.rx[14:0], sdi};
        end
        if (q.busy && fall) begin
            d.sh  = {q.sh[14:0], 1'b0};
            d.cnt = q.cnt - 5'h01;
            if (q.cnt == 5'h01) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end
        if (start) begin
            d.busy = 1'b1;
            d.cnt  = wide ? qspc_pkg::BITS_WIDE : qspc_pkg::BITS_NARROW;
            d.sh   = wide ? tx : {tx[7:0], 8'h00};
            d.rx   = 16'h0000;
            d.div  = 8'h00;
            d.sck  = 1'b0;
        end
        // Abort drops the word in flight; the far end may see a short frame.
        if (abort) begin
            d.busy = 1'b0;
            d.done = 1'b0;
            d.sck  = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sck_o = q.sck;
    assign sdo   = q.sh[15];
    assign done  = q.done;
    assign rx    = q.rx;
endmodule : qspc_shift

// File: hw/qspc_ctl.sv
// Queue sequencer, flags, halt and chip select control of the queued serial port.
module qspc_ctl (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        enable_wr,
    input  wire logic        enable_wdata,
    input  wire logic        master_select,
    input  wire logic        wrap_enable,
    input  wire logic        ss_is_input,
    input  wire logic        halt_request,
    input  wire logic        start_ptr_wr,
    input  wire logic [4:0]  start_ptr_wdata,
    input  wire logic        end_ptr_wr,
    input  wire logic [4:0]  end_ptr_wdata,
    input  wire logic        status_wr,
    input  wire logic [2:0]  status_wdata,
    input  wire logic [3:0]  pin_idle_value_register,
    input  wire logic        cpu_ram_wr,
    input  wire logic [7:0]  cpu_ram_addr,
    input  wire logic [7:0]  cpu_ram_wdata,
    output logic      [7:0]  cpu_ram_rdata,
    output logic             serial_enable_bit,
    output logic      [4:0]  queue_start_pointer,
    output logic      [4:0]  queue_end_pointer,
    output logic      [4:0]  active_pointer,
    output logic      [2:0]  queue_status_register,
    output logic             queue_done_flag,
    output logic             mode_fault_flag,
    output logic             halt_acknowledge_flag,
    output logic             irq,
    input  wire logic        first_chip_select_or_slave_select_i,
    output logic      [3:0]  chip_select_o,
    output logic      [3:0]  chip_select_oe,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        qspc_pkg::qspc_state_t st;
        logic                  en;
        logic [4:0]            start;
        logic [4:0]            endp;
        logic [4:0]            ptr;
        logic                  pend;
        logic [2:0]            flags;
        logic [3:0]            cs;
        logic [3:0]            cs_out;
        logic                  hold;
        logic                  wide;
        logic                  go;
        logic                  ss1;
        logic                  ss2;
        logic                  sck1;
        logic                  sck2;
        logic                  mo1;
        logic                  mo2;
        logic                  mi1;
        logic                  mi2;
    } qspc_ctl_t;

    qspc_ctl_t   q;
    qspc_ctl_t   d;
    logic [15:0] eng_tx;
    logic [7:0]  eng_cmd;
    logic [15:0] shift_rx;
    logic        shift_done;
    logic        shift_sdo;
    logic        match;
    logic        eng_wr;
    logic        fault;

    assign match  = q.ptr == q.endp;
    assign eng_wr = q.st == qspc_pkg::ST_XFER && shift_done;
    assign fault  = q.en && master_select && ss_is_input && !q.ss2;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Hardware events are applied after software writes, so a set beats a clear.
    always_comb begin
        d       = q;
        d.go    = 1'b0;
        d.ss1   = first_chip_select_or_slave_select_i;
        d.ss2   = q.ss1;
        d.sck1  = sck_i;
        d.sck2  = q.sck1;
        d.mo1   = mosi_i;
        d.mo2   = q.mo1;
        d.mi1   = miso_i;
        d.mi2   = q.mi1;
        if (start_ptr_wr) begin
            d.start = start_ptr_wdata;
            if (q.st == qspc_pkg::ST_LOAD || q.st == qspc_pkg::ST_XFER) begin
                d.pend = 1'b1;
            end else begin
                d.ptr = start_ptr_wdata;
            end
        end
        if (end_ptr_wr) begin
            d.endp = end_ptr_wdata;
        end
        if (status_wr) begin
            d.flags = q.flags & status_wdata;
        end
        if (enable_wr) begin
            d.en = enable_wdata;
        end
        case (q.st)
            qspc_pkg::ST_IDLE: begin
                if (q.en) begin
                    d.st   = qspc_pkg::ST_LOAD;
                    d.ptr  = q.start;
                    d.pend = 1'b0;
                end
            end
            qspc_pkg::ST_LOAD: begin
                d.cs   = eng_cmd[qspc_pkg::CS_W-1:0];
                d.hold = eng_cmd[qspc_pkg::CMD_HOLD_BIT];
                d.wide = eng_cmd[qspc_pkg::CMD_WIDE_BIT];
                // A slave waits for the remote master to pull slave select low.
                if (master_select || !q.ss2) begin
                    d.go = 1'b1;
                    d.st = qspc_pkg::ST_XFER;
                end
            end
            qspc_pkg::ST_XFER: begin
                if (shift_done) begin
                    d.pend = 1'b0;
                    if (match && !wrap_enable) begin
                        d.flags[qspc_pkg::FLAG_DONE] = 1'b1;
                        d.en  = 1'b0;
                        d.st  = qspc_pkg::ST_IDLE;
                        d.ptr = q.start;
                        if (halt_request) begin
                            d.flags[qspc_pkg::FLAG_HALT_ACKNOWLEDGE_FLAG] = 1'b1;
                        end
                    end else begin
                        d.ptr = (q.pend || match) ? q.start : q.ptr + 5'h01;
                        if (halt_request) begin
                            d.st = qspc_pkg::ST_HALT;
                            d.flags[qspc_pkg::FLAG_HALT_ACKNOWLEDGE_FLAG] = 1'b1;
                        end else begin
                            d.st = qspc_pkg::ST_LOAD;
                        end
                    end
                end
            end
            qspc_pkg::ST_HALT: begin
                if (!halt_request) begin
                    d.st = qspc_pkg::ST_LOAD;
                end
            end
            default: begin
                d.st = qspc_pkg::ST_IDLE;
            end
        endcase
        if (fault) begin
            d.flags[qspc_pkg::FLAG_MODE_FAULT_FLAG] = 1'b1;
            d.en = 1'b0;
        end
        // Losing enable ends everything at once, mid-word or not.
        if (!d.en) begin
            d.st = qspc_pkg::ST_IDLE;
            d.go = 1'b0;
        end
        // Chip selects follow the command while busy, else hold or idle value.
        if (d.st == qspc_pkg::ST_LOAD || d.st == qspc_pkg::ST_XFER || d.hold) begin
            d.cs_out = d.cs;
        end else begin
            d.cs_out = pin_idle_value_register;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q        <= '0;
            q.st     <= qspc_pkg::ST_IDLE;
            q.start  <= qspc_pkg::PTR_RESET;
            q.endp   <= qspc_pkg::PTR_RESET;
            q.ptr    <= qspc_pkg::PTR_RESET;
            q.flags  <= qspc_pkg::FLAGS_RESET;
            q.ss1    <= 1'b1;
            q.ss2    <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Queue memory and shifter
    // ------------------------------------------------------------------
    qspc_ram u_ram (
        .clock     (clock),
        .rst       (rst),
        .cpu_wr    (cpu_ram_wr),
        .cpu_addr  (cpu_ram_addr),
        .cpu_wdata (cpu_ram_wdata),
        .cpu_rdata (cpu_ram_rdata),
        .eng_idx   (q.ptr),
        .eng_tx    (eng_tx),
        .eng_cmd   (eng_cmd),
        .eng_wr    (eng_wr),
        .eng_rx    (shift_rx)
    );

    qspc_shift u_shift (
        .clock  (clock),
        .rst    (rst),
        .start  (q.go),
        .abort  (!q.en),
        .master (master_select),
        .wide   (q.wide),
        .tx     (eng_tx),
        .sck_s  (q.sck2),
        .sdi    (master_select ? q.mi2 : q.mo2),
        .sck_o  (sck_o),
        .sdo    (shift_sdo),
        .done   (shift_done),
        .rx     (shift_rx)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // One request line; software reads the status to find the cause.
    assign irq                   = |q.flags;
    assign serial_enable_bit     = q.en;
    assign queue_start_pointer   = q.start;
    assign queue_end_pointer     = q.endp;
    assign active_pointer        = q.ptr;
    assign queue_status_register = q.flags;
    assign queue_done_flag       = q.flags[qspc_pkg::FLAG_DONE];
    assign mode_fault_flag       = q.flags[qspc_pkg::FLAG_MODE_FAULT_FLAG];
    assign halt_acknowledge_flag = q.flags[qspc_pkg::FLAG_HALT_ACKNOWLEDGE_FLAG];
    assign chip_select_o         = q.cs_out;
    assign chip_select_oe        = {{3{master_select}}, master_select && !ss_is_input};
    assign sck_oe                = master_select && q.en;
    assign mosi_o                = shift_sdo;
    assign mosi_oe               = master_select && q.en;
    assign miso_o                = shift_sdo;
    assign miso_oe               = !master_select && q.en && !q.ss2;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_last_done;
        eng_wr && match && !wrap_enable && !fault;
    endsequence
    sequence s_mid_halt;
        eng_wr && !(match && !wrap_enable) && halt_request && !fault && q.en && !enable_wr;
    endsequence

    a_reset_ptrs: assert property ($fell(rst) |-> q.start == qspc_pkg::PTR_RESET
                                   && q.endp == qspc_pkg::PTR_RESET && q.flags == qspc_pkg::FLAGS_RESET)
        else $error("pointers not zero after reset");
    a_last_stop: assert property (s_last_done |=> queue_done_flag && !serial_enable_bit
                                  && q.st == qspc_pkg::ST_IDLE)
        else $error("queue end did not stop and disable");
    a_ptr_advance: assert property (eng_wr && !match && !q.pend && !start_ptr_wr |=>
                                    active_pointer == $past(q.ptr) + 5'h01)
        else $error("pointer did not advance by one");
    a_wrap_return: assert property (eng_wr && match && wrap_enable && !fault && !enable_wr |=>
                                    active_pointer == $past(q.start) && serial_enable_bit)
        else $error("wraparound did not return to start");
    a_mode_fault: assert property (fault |=> mode_fault_flag && !serial_enable_bit)
        else $error("mode fault not flagged");
    a_halt_ack: assert property (s_mid_halt |=> q.st == qspc_pkg::ST_HALT && halt_acknowledge_flag
                                 && serial_enable_bit && !$rose(queue_done_flag))
        else $error("halt not acknowledged on boundary");
    a_halt_last: assert property (s_last_done and halt_request |=>
                                  halt_acknowledge_flag && queue_done_flag && !serial_enable_bit)
        else $error("halt on last command mishandled");
    a_resume: assert property (q.st == qspc_pkg::ST_HALT && !halt_request && q.en && !fault && !enable_wr
                               |=> q.st == qspc_pkg::ST_LOAD ##1 q.st == qspc_pkg::ST_XFER || !q.en
                               || !master_select)
        else $error("did not resume after halt cleared");
    a_disable_now: assert property (enable_wr && !enable_wdata |=> q.st == qspc_pkg::ST_IDLE
                                    ##1 !shift_done[*2])
        else $error("disable did not stop at once");
    a_flag_clear: assert property (status_wr && !status_wdata[qspc_pkg::FLAG_MODE_FAULT_FLAG] && !fault
                                   |=> !mode_fault_flag)
        else $error("status write zero did not clear");
    a_irq_join: assert property (irq == (queue_done_flag || mode_fault_flag || halt_acknowledge_flag))
        else $error("interrupt not the join of flags");
    a_cs_halted: assert property (q.st == qspc_pkg::ST_HALT && $stable(q.st) |->
                                  chip_select_o == (q.hold ? q.cs : $past(pin_idle_value_register)))
        else $error("chip selects wrong while halted");
endmodule : qspc_ctl

// File: verif/qspc_peer.sv
// Serial peripheral model that answers each master word with a fixed reply.
module qspc_peer #(
    parameter logic [15:0] REPLY = 16'h1234
) (
    input  wire logic        clock,
    input  wire logic        sel,
    input  wire logic        sck,
    input  wire logic        mosi,
    output logic             miso,
    output logic      [15:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       sck_q;
    logic       last_q = 1'b0;
    logic [3:0] idx_q;
    // Bits move on the falling edge so that they are settled at the master's rising edge.
    always_ff @(posedge clock) begin
        sck_q <= sck;
        last_q <= miso;
        if (!sel) begin
            idx_q <= 4'h0;
        end else if (sck_q && !sck) begin
            idx_q <= idx_q + 4'h1;
        end
        if (!sck_q && sck) begin
            got <= {got[14:0], mosi};
        end
    end
    // A released line toggles, so that stale data never passes for a reply.
    assign miso = sel ? REPLY[4'hf - idx_q] : ~last_q;
endmodule : qspc_peer

// File: verif/qspc_ctl_bench.sv
// Bench of the queued serial control block facing a peer device.
module qspc_ctl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] REPLY = 16'h3ca5;
    logic clock = 1'b0, rst = 1'b1, enable_wr = 1'b0, enable_wdata = 1'b0, master_select = 1'b1;
    logic wrap_enable = 1'b0, ss_is_input = 1'b0, halt_request = 1'b0, start_ptr_wr = 1'b0;
    logic end_ptr_wr = 1'b0, status_wr = 1'b0, cpu_ram_wr = 1'b0, sck_i = 1'b0, mosi_i = 1'b0;
    logic first_chip_select_or_slave_select_i = 1'b1, miso_i, serial_enable_bit, irq;
    logic queue_done_flag, mode_fault_flag, halt_acknowledge_flag, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic [4:0] start_ptr_wdata = 5'h00, end_ptr_wdata = 5'h00, queue_start_pointer, queue_end_pointer, active_pointer;
    logic [2:0] status_wdata = 3'h0, queue_status_register;
    logic [3:0] pin_idle_value_register = 4'h9, chip_select_o, chip_select_oe, cs0;
    logic [7:0] cpu_ram_addr = 8'h00, cpu_ram_wdata = 8'h00, cpu_ram_rdata;
    logic [15:0] got, tx[3];
    int err_count = 0, comparisons = 0, seed = 43, s;
    qspc_ctl dut_u (.*);
    qspc_peer #(.REPLY(REPLY)) peer_u (.clock(clock), .sel(serial_enable_bit), .sck(sck_o), .mosi(mosi_o),
                                       .miso(miso_i), .got(got));
    // ----------------
    // Helper tasks
    // ----------------
    always #5 clock = ~clock;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic ram_put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        {cpu_ram_addr, cpu_ram_wdata, cpu_ram_wr} <= {a, d, 1'b1};
        @(posedge clock);
        cpu_ram_wr <= 1'b0;
    endtask : ram_put
    task automatic ram_get(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        cpu_ram_addr <= a;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk(cpu_ram_rdata, e);
    endtask : ram_get
    // One strobe kind per call: 0 enable, 1 status, 2 start pointer, 3 end pointer.
    task automatic strobe(input int k, input logic [4:0] v);
        @(posedge clock);
        {enable_wdata, status_wdata, start_ptr_wdata, end_ptr_wdata} <= {v[0], v[2:0], v, v};
        {enable_wr, status_wr, start_ptr_wr, end_ptr_wr} <= 4'(4'h8 >> k);
        @(posedge clock);
        {enable_wr, status_wr, start_ptr_wr, end_ptr_wr} <= 4'h0;
        @(negedge clock);
    endtask : strobe
    // The bound covers a three word queue of 16 bits with margin.
    task automatic wait_stat(input int f);
        int n;
        for (n = 0; n < 6000 && queue_status_register[f] !== 1'b1; n++) @(posedge clock);
        if (n == 6000) chk(16'h0, 16'h1);
        @(negedge clock);
    endtask : wait_stat
    task automatic load(input logic [4:0] i, input logic [15:0] w, input logic [7:0] c);
        ram_put(qspc_pkg::TX_BASE + {2'b00, i, 1'b0}, w[15:8]);
        ram_put(qspc_pkg::TX_BASE + {2'b00, i, 1'b1}, w[7:0]);
        ram_put(qspc_pkg::CMD_BASE + {3'b000, i}, c);
    endtask : load
    // Remote master for slave mode: data moves half a link period before each rising edge.
    task automatic remote(input logic [15:0] w, output logic [15:0] r);
        for (int b = 15; b >= 0; b--) begin
            mosi_i <= w[b];
            #62.5 sck_i <= 1'b1;
            r = {r[14:0], miso_o};
            #62.5 sck_i <= 1'b0;
        end
    endtask : remote
    task automatic print_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // Main sequence: single word, status clearing, halted queue, halt on last, fault, wrap, abort, slave.
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk({serial_enable_bit, queue_start_pointer, queue_end_pointer,
             queue_status_register, irq}, 16'h0);
        tx[0] = 16'($random(seed));
        load(5'h00, tx[0], 8'h40);
        ram_put(qspc_pkg::RX_BASE + 8'h02, 8'h5a);
        ram_put(8'ha0, 8'h77);
        strobe(0, 5'h01);
        wait_stat(qspc_pkg::FLAG_DONE);
        chk({serial_enable_bit, irq}, 16'h1);
        chk({chip_select_o, chip_select_oe, sck_oe, mosi_oe, miso_oe, active_pointer}, 16'h9f00);
        chk(got, tx[0]);
        ram_get(qspc_pkg::RX_BASE + 8'h01, REPLY[7:0]);
        ram_get(qspc_pkg::RX_BASE + 8'h02, 8'h5a);
        ram_get(8'ha0, 8'h00);
        strobe(1, 5'h07);
        chk(queue_status_register, 16'h1);
        strobe(1, 5'h06);
        chk({queue_done_flag, irq}, 16'h0);
        s = {$random(seed)} % 30;
        for (int k = 0; k < 3; k++) begin
            tx[k] = 16'($random(seed));
            cs0 = (k == 0) ? 4'($random(seed)) : cs0;
            load(5'(s + k), tx[k], {4'hc, cs0});
        end
        strobe(2, 5'(s));
        strobe(3, 5'(s + 2));
        @(posedge clock) halt_request <= 1'b1;
        strobe(0, 5'h01);
        wait_stat(qspc_pkg::FLAG_HALT_ACKNOWLEDGE_FLAG);
        chk({serial_enable_bit, queue_done_flag, chip_select_o, sck_oe, mosi_oe},
            {8'h0, 2'b10, cs0, 2'b11});
        repeat (50) @(posedge clock);
        halt_request <= 1'b0;
        @(negedge clock);
        chk(halt_acknowledge_flag, 16'h1);
        strobe(1, 5'h03);
        wait_stat(qspc_pkg::FLAG_DONE);
        chk(got, tx[2]);
        chk(serial_enable_bit, 16'h0);
        strobe(1, 5'h00);
        strobe(2, 5'(s + 2));
        strobe(0, 5'h01);
        repeat (100) @(posedge clock);
        halt_request <= 1'b1;
        wait_stat(qspc_pkg::FLAG_DONE);
        chk({serial_enable_bit, halt_acknowledge_flag}, 16'h1);
        @(posedge clock) {halt_request, ss_is_input, first_chip_select_or_slave_select_i} <= 3'b010;
        strobe(1, 5'h00);
        strobe(0, 5'h01);
        wait_stat(qspc_pkg::FLAG_MODE_FAULT_FLAG);
        chk({serial_enable_bit, irq, mode_fault_flag, chip_select_oe}, 16'h3e);
        // Wraparound never finishes, so the bench halts it on a word boundary and then clears enable.
        @(posedge clock) {wrap_enable, ss_is_input, first_chip_select_or_slave_select_i} <= 3'b101;
        strobe(1, 5'h00);
        strobe(0, 5'h01);
        repeat (1000) @(posedge clock);
        halt_request <= 1'b1;
        wait_stat(qspc_pkg::FLAG_HALT_ACKNOWLEDGE_FLAG);
        strobe(0, 5'h00);
        chk({serial_enable_bit, queue_status_register}, 16'h4);
        @(posedge clock) {wrap_enable, halt_request} <= 2'b00;
        strobe(1, 5'h00);
        strobe(0, 5'h01);
        repeat (200) @(posedge clock);
        strobe(0, 5'h00);
        repeat (900) @(posedge clock);
        chk({serial_enable_bit, queue_status_register}, 16'h0);
        // Slave mode: the bench plays the remote master on entry s + 2.
        @(posedge clock) {master_select, ss_is_input, first_chip_select_or_slave_select_i} <= 3'b010;
        tx[1] = 16'($random(seed));
        strobe(0, 5'h01);
        repeat (4) @(posedge clock);
        remote(tx[1], tx[0]);
        wait_stat(qspc_pkg::FLAG_DONE);
        chk(tx[0], tx[2]);
        chk({serial_enable_bit, chip_select_oe, sck_oe}, 16'h0);
        ram_get(8'(2 * s + 4), tx[1][15:8]);
        print_verdict();
    end
    // Watchdog well beyond the expected run of about 70 us.
    initial begin
        #300us;
        err_count++;
        print_verdict();
    end
endmodule : qspc_ctl_bench
